// ### src/sxt_regs.sv
// Exchange trigger register bank for a two-port serial communication module
//
// Functional notes
// RULE1: First port read trigger: high byte drives bit reads, low byte word reads.
// RULE2: Each trigger byte: 0 none, 1 single pass, 2 continuous passes.
// RULE3: First port read: writing 1 or 2 starts, writing 0 stops.
// RULE4: First port write trigger: high byte bit writes, low byte word writes.
// RULE5: First port write: writing 1 or 2 starts, writing 0 stops.
// RULE6: Second port read trigger behaves like the first port's.
// RULE7: Second port write trigger: high byte bit, low byte word, same encoding.
// RULE8: Writing a group number launches that group's exchange on the first port.
// RULE9: Group trigger clears to 0 once launched; resets to 0.
// RULE10: Outgoing data index is send base plus configured offset.
// RULE11: Incoming data index is receive base plus configured offset.
// RULE12: Second port has its own group trigger, send base, receive base.
// RULE13: Sequence count: high byte first port, low byte second port.
// RULE14: Sequence count 0 runs nothing; 1 to 254 run exactly that often.
// RULE15: Sequence count 255 repeats without limit until changed.
// RULE16: Port 1 bit read map: 16 words, bit b0 of first word is entry 1.
// RULE17: Map bit 0 disables an entry, 1 enables it.
// RULE18: Port 1 word read map: 16 words, same ordering.
// RULE19: Port 1 bit write map: 16 words, ascending from b0.
// RULE20: Port 1 word write map: 16 words, same ordering.
// RULE21: Port 2 bit read map: 16 words, same layout.
// RULE22: Single pass stops after one walk; continuous restarts until byte is 0.
// RULE23: Only entries with map bit 1 are requested; channels 5 to 7 have no map and request every entry.
`timescale 1ns/100ps
`include "sxt_defs.svh"
module sxt_regs import sxt_pkg::*; (
   clk_sys,
   reset,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata,
   reg_ack,
   xfer_req,
   xfer_idx,
   xfer_ack,
   xfer_busy,
   xfer_pass_done,
   grp_start,
   grp_num,
   seq_req,
   seq_done,
   map_offset,
   send_index,
   recv_index
);
   input wire logic clk_sys;
   input wire logic reset;
   input wire logic reg_wr;
   input wire logic reg_rd;
   input wire logic [15:0] reg_addr;
   input wire logic [15:0] reg_wdata;
   output logic [15:0] reg_rdata;
   output logic reg_ack;
   output logic [7:0] xfer_req;
   output logic [63:0] xfer_idx;
   input wire logic [7:0] xfer_ack;
   output logic [7:0] xfer_busy;
   output logic [7:0] xfer_pass_done;
   output logic [1:0] grp_start;
   output logic [31:0] grp_num;
   output logic [1:0] seq_req;
   input wire logic [1:0] seq_done;
   input wire logic [31:0] map_offset;
   output logic [31:0] send_index;
   output logic [31:0] recv_index;

   localparam logic [4:0][15:0] MAP_BASE = {
      `SXT_CR_P2_BIT_RD_MAP, `SXT_CR_P1_WORD_WR_MAP, `SXT_CR_P1_BIT_WR_MAP,
      `SXT_CR_P1_WORD_RD_MAP, `SXT_CR_P1_BIT_RD_MAP};
   localparam logic [3:0][15:0] TRIG_ADDR = {
      `SXT_CR_P2_WRITE_TRIG, `SXT_CR_P2_READ_TRIG,
      `SXT_CR_P1_WRITE_TRIG, `SXT_CR_P1_READ_TRIG};
   localparam logic [1:0][15:0] GRP_ADDR = {`SXT_CR_P2_GROUP_TRIG, `SXT_CR_P1_GROUP_TRIG};
   localparam logic [1:0][15:0] SBASE_ADDR = {`SXT_CR_P2_SEND_BASE, `SXT_CR_P1_SEND_BASE};
   localparam logic [1:0][15:0] RBASE_ADDR = {`SXT_CR_P2_RECV_BASE, `SXT_CR_P1_RECV_BASE};

   sxt_regs_t s_ff;
   sxt_regs_t nxt_s;
   sxt_mode_t [7:0] ch_mode;
   logic [7:0] ch_en;
   logic [7:0][7:0] ch_idx;
   logic [3:0] sel_trig;
   logic [1:0] sel_grp;
   logic [1:0] sel_sbase;
   logic [1:0] sel_rbase;
   logic sel_seq;
   logic [4:0] sel_map;
   logic [3:0] map_k;
   sxt_mode_t wr_hi_mode;
   sxt_mode_t wr_lo_mode;
   logic [15:0] rd_word;

   // Unknown byte values act as no trigger, so a stray write can only stop
   function automatic sxt_mode_t trig_mode(input logic [7:0] b);
      sxt_mode_t m;
      m = SXT_MODE_NONE;
      if (b == 8'h01) begin
         m = SXT_MODE_ONCE;
      end else if (b == 8'h02) begin
         m = SXT_MODE_CONT;
      end
      return m;
   endfunction

   function automatic logic map_hit(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return (a >= base) && (d < `SXT_MAP_WORDS);
   endfunction

   function automatic logic [3:0] map_word(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return d[3:0];
   endfunction

   function automatic logic [7:0] hi_byte(input logic [15:0] w);
      return w[`SXT_HI_BYTE_LSB +: 8];
   endfunction

   function automatic logic [7:0] lo_byte(input logic [15:0] w);
      return w[`SXT_LO_BYTE_LSB +: 8];
   endfunction

   // Entry i sits in word i/16 at bit i%16
   function automatic logic entry_on(input logic [15:0][15:0] words, input logic [7:0] i);
      return words[i[7:4]][i[3:0]];
   endfunction

   // One select bit per table entry, so the write and read paths decode alike
   function automatic logic [3:0] hit4(input logic [15:0] a, input logic [3:0][15:0] tab);
      logic [3:0] h;
      h = 4'h0;
      for (int i = 0; i < 4; i++) begin
         h[i] = (a == tab[i]);
      end
      return h;
   endfunction

   function automatic logic [1:0] hit2(input logic [15:0] a, input logic [1:0][15:0] tab);
      logic [1:0] h;
      h = 2'h0;
      for (int i = 0; i < 2; i++) begin
         h[i] = (a == tab[i]);
      end
      return h;
   endfunction

   // Address and data decode shared by the write and read paths
   always_comb begin
      sel_trig = hit4(reg_addr, TRIG_ADDR);
      sel_grp = hit2(reg_addr, GRP_ADDR);
      sel_sbase = hit2(reg_addr, SBASE_ADDR);
      sel_rbase = hit2(reg_addr, RBASE_ADDR);
      sel_seq = (reg_addr == `SXT_CR_SEQ_COUNT);
      sel_map = 5'h00;
      map_k = 4'h0;
      for (int m = 0; m < 5; m++) begin
         if (map_hit(reg_addr, MAP_BASE[m])) begin
            sel_map[m] = 1'b1;
            map_k = map_word(reg_addr, MAP_BASE[m]);
         end
      end
      wr_hi_mode = trig_mode(hi_byte(reg_wdata));
      wr_lo_mode = trig_mode(lo_byte(reg_wdata));
   end

   // Trigger word t feeds channel 2t from its high byte and 2t+1 from its low byte
   always_comb begin
      for (int t = 0; t < 4; t++) begin
         ch_mode[2*t] = trig_mode(s_ff.trig[t][`SXT_HI_BYTE_LSB +: 8]); // see RULE1
         ch_mode[2*t+1] = trig_mode(s_ff.trig[t][`SXT_LO_BYTE_LSB +: 8]); // see RULE4
      end
   end

   // Channels without a map of their own run every entry
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         if (c < 5) begin
            ch_en[c] = entry_on(s_ff.map[c], ch_idx[c]); // see RULE17
         end else begin
            ch_en[c] = 1'b1;
         end
      end
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.ack = reg_rd | reg_wr;
      nxt_s.start = 8'h00;
      nxt_s.stop = 8'h00;
      nxt_s.grp_start = 2'b00;

      for (int p = 0; p < 2; p++) begin
         // Launch a pending group, then clear it so software sees it taken
         if (s_ff.grp[p] != 16'h0000) begin
            nxt_s.grp_start[p] = 1'b1; // see RULE8
            nxt_s.grp_num[p] = s_ff.grp[p];
            nxt_s.grp[p] = 16'h0000; // see RULE9
         end
         if (seq_done[p] && s_ff.rem[p] != 8'h00 && s_ff.rem[p] != `SXT_SEQ_FOREVER) begin
            nxt_s.rem[p] = s_ff.rem[p] - 8'h01; // see RULE14 RULE15
         end
         nxt_s.sidx[p] = s_ff.sbase[p] + map_offset[16*p +: 16]; // see RULE10
         nxt_s.ridx[p] = s_ff.rbase[p] + map_offset[16*p +: 16]; // see RULE11
      end

      if (reg_wr) begin
         for (int t = 0; t < 4; t++) begin
            if (sel_trig[t]) begin
               nxt_s.trig[t] = reg_wdata; // see RULE2
               // A nonzero mode (re)starts the walk, zero stops it
               if (wr_hi_mode == SXT_MODE_NONE) begin
                  nxt_s.stop[2*t] = 1'b1; // see RULE3
               end else begin
                  nxt_s.start[2*t] = 1'b1; // see RULE5
               end
               if (wr_lo_mode == SXT_MODE_NONE) begin
                  nxt_s.stop[2*t+1] = 1'b1; // see RULE6
               end else begin
                  nxt_s.start[2*t+1] = 1'b1; // see RULE7
               end
            end
         end
         for (int p = 0; p < 2; p++) begin
            if (sel_grp[p]) begin
               nxt_s.grp[p] = reg_wdata; // see RULE12
            end
            if (sel_sbase[p]) begin
               nxt_s.sbase[p] = reg_wdata;
            end
            if (sel_rbase[p]) begin
               nxt_s.rbase[p] = reg_wdata;
            end
         end
         if (sel_seq) begin
            // A new count replaces whatever remains, which also ends 255
            nxt_s.seq = reg_wdata;
            nxt_s.rem[0] = hi_byte(reg_wdata); // see RULE13
            nxt_s.rem[1] = lo_byte(reg_wdata); // see RULE13
         end
         for (int m = 0; m < 5; m++) begin
            if (sel_map[m]) begin
               // Word k holds entries 16k+1 at b0 up to 16k+16 at b15
               nxt_s.map[m][map_k] = reg_wdata; // see RULE16
            end
         end
      end

      for (int p = 0; p < 2; p++) begin
         nxt_s.seq_req[p] = (nxt_s.rem[p] != 8'h00); // see RULE14
      end

      if (reg_rd) begin
         nxt_s.rdata = rd_word;
      end
   end

   // Mux over the stored values, so a read beside a write returns the old word
   always_comb begin
      rd_word = 16'h0000;
      for (int t = 0; t < 4; t++) begin
         if (sel_trig[t]) begin
            rd_word = s_ff.trig[t];
         end
      end
      for (int p = 0; p < 2; p++) begin
         if (sel_grp[p]) begin
            rd_word = s_ff.grp[p];
         end
         if (sel_sbase[p]) begin
            rd_word = s_ff.sbase[p];
         end
         if (sel_rbase[p]) begin
            rd_word = s_ff.rbase[p];
         end
      end
      if (sel_seq) begin
         rd_word = s_ff.seq;
      end
      for (int m = 0; m < 5; m++) begin
         if (sel_map[m]) begin
            rd_word = s_ff.map[m][map_k]; // see RULE18
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_ff.trig <= {4{`SXT_RST_TRIG}};
         s_ff.grp <= {2{`SXT_RST_GROUP}};
         s_ff.sbase <= {2{`SXT_RST_BASE}};
         s_ff.rbase <= {2{`SXT_RST_BASE}};
         s_ff.seq <= `SXT_RST_SEQ;
         s_ff.rem <= 16'h0000;
         s_ff.map <= {80{`SXT_RST_MAP}}; // see RULE19
         s_ff.rdata <= 16'h0000;
         s_ff.ack <= 1'b0;
         s_ff.start <= 8'h00;
         s_ff.stop <= 8'h00;
         s_ff.grp_start <= 2'b00;
         s_ff.grp_num <= 32'h0000_0000;
         s_ff.seq_req <= 2'b00;
         s_ff.sidx <= 32'h0000_0000;
         s_ff.ridx <= 32'h0000_0000;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Channel c: port c/4, kinds bit read, word read, bit write, word write
   for (genvar c = 0; c < 8; c++) begin : g_ch
      sxt_scan u_scan (
         .clk_sys(clk_sys),
         .reset(reset),
         .mode(ch_mode[c]),
         .start(s_ff.start[c]),
         .stop(s_ff.stop[c]),
         .entry_en(ch_en[c]), // see RULE20
         .ack(xfer_ack[c]),
         .req(xfer_req[c]),
         .idx(ch_idx[c]),
         .busy(xfer_busy[c]),
         .pass_done(xfer_pass_done[c]) // see RULE22
      );
      assign xfer_idx[8*c +: 8] = ch_idx[c]; // see RULE21
   end

   assign reg_rdata = s_ff.rdata;
   assign reg_ack = s_ff.ack;
   assign grp_start = s_ff.grp_start;
   assign grp_num = s_ff.grp_num;
   assign seq_req = s_ff.seq_req;
   assign send_index = s_ff.sidx;
   assign recv_index = s_ff.ridx;

endmodule

// ### src/sxt_defs.svh
// Register offsets, field positions, reset values and counts of the exchange trigger bank
`ifndef SXT_DEFS_SVH
`define SXT_DEFS_SVH

`define SXT_CR_P1_READ_TRIG 16'h0007
`define SXT_CR_P1_WRITE_TRIG 16'h0008
`define SXT_CR_P2_READ_TRIG 16'h0011
`define SXT_CR_P2_WRITE_TRIG 16'h0012
`define SXT_CR_P1_GROUP_TRIG 16'h0015
`define SXT_CR_P1_SEND_BASE 16'h0016
`define SXT_CR_P1_RECV_BASE 16'h0017
`define SXT_CR_P2_GROUP_TRIG 16'h0019
`define SXT_CR_P2_SEND_BASE 16'h001a
`define SXT_CR_P2_RECV_BASE 16'h001b
`define SXT_CR_SEQ_COUNT 16'h001c

`define SXT_CR_P1_BIT_RD_MAP 16'h1003
`define SXT_CR_P1_WORD_RD_MAP 16'h2003
`define SXT_CR_P1_BIT_WR_MAP 16'h3003
`define SXT_CR_P1_WORD_WR_MAP 16'h4003
`define SXT_CR_P2_BIT_RD_MAP 16'h5003
`define SXT_MAP_WORDS 16'h0010

`define SXT_HI_BYTE_LSB 8
`define SXT_LO_BYTE_LSB 0

`define SXT_RST_TRIG 16'h0000
`define SXT_RST_GROUP 16'h0000
`define SXT_RST_BASE 16'h0000
`define SXT_RST_SEQ 16'h0000
`define SXT_RST_MAP 16'h0000

`define SXT_SEQ_FOREVER 8'hff
`define SXT_LAST_ENTRY 8'hff

`endif

// ### src/sxt_pkg.sv
// Types shared by the exchange trigger bank and its entry scanner
package sxt_pkg;

   typedef enum logic [1:0] {
      SXT_MODE_NONE = 2'h0,
      SXT_MODE_ONCE = 2'h1,
      SXT_MODE_CONT = 2'h2
   } sxt_mode_t;

   typedef enum logic [1:0] {
      SXT_SCAN_IDLE = 2'h0,
      SXT_SCAN_WALK = 2'h1,
      SXT_SCAN_REQ = 2'h3
   } sxt_scan_st_t;

   typedef struct packed {
      sxt_scan_st_t st;
      logic [7:0] idx;
      logic req;
      logic busy;
      logic done;
   } sxt_scan_t;

   typedef struct packed {
      logic [3:0][15:0] trig;
      logic [1:0][15:0] grp;
      logic [1:0][15:0] sbase;
      logic [1:0][15:0] rbase;
      logic [15:0] seq;
      logic [1:0][7:0] rem;
      logic [4:0][15:0][15:0] map;
      logic [15:0] rdata;
      logic ack;
      logic [7:0] start;
      logic [7:0] stop;
      logic [1:0] grp_start;
      logic [1:0][15:0] grp_num;
      logic [1:0] seq_req;
      logic [1:0][15:0] sidx;
      logic [1:0][15:0] ridx;
   } sxt_regs_t;

endpackage

// ### src/sxt_scan.sv
// Walks the 256 entries of one exchange channel, requesting only enabled ones
`timescale 1ns/100ps
`include "sxt_defs.svh"
module sxt_scan import sxt_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset,
   input wire sxt_mode_t mode,
   input wire logic start,
   input wire logic stop,
   input wire logic entry_en,
   input wire logic ack,
   output logic req,
   output logic [7:0] idx,
   output logic busy,
   output logic pass_done
);

   sxt_scan_t s_ff;
   sxt_scan_t nxt_s;
   logic advance;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      advance = 1'b0;
      if (stop) begin
         // Stop aborts even a request in flight; the far side must drop it
         nxt_s.st = SXT_SCAN_IDLE;
         nxt_s.req = 1'b0;
         nxt_s.busy = 1'b0;
      end else if (start) begin
         nxt_s.st = SXT_SCAN_WALK;
         nxt_s.idx = 8'h00;
         nxt_s.req = 1'b0;
         nxt_s.busy = 1'b1;
      end else begin
         unique case (s_ff.st)
            SXT_SCAN_IDLE: begin
            end
            SXT_SCAN_WALK: begin
               if (entry_en) begin // see RULE23
                  nxt_s.st = SXT_SCAN_REQ;
                  nxt_s.req = 1'b1;
               end else begin
                  advance = 1'b1;
               end
            end
            SXT_SCAN_REQ: begin
               if (ack) begin
                  nxt_s.req = 1'b0;
                  advance = 1'b1;
               end
            end
            default: begin
               nxt_s.st = SXT_SCAN_IDLE;
               nxt_s.req = 1'b0;
               nxt_s.busy = 1'b0;
            end
         endcase
         if (advance) begin
            if (s_ff.idx == `SXT_LAST_ENTRY) begin
               nxt_s.done = 1'b1;
               if (mode == SXT_MODE_CONT) begin // see RULE22
                  nxt_s.st = SXT_SCAN_WALK;
                  nxt_s.idx = 8'h00;
               end else begin
                  nxt_s.st = SXT_SCAN_IDLE;
                  nxt_s.busy = 1'b0;
               end
            end else begin
               nxt_s.st = SXT_SCAN_WALK;
               nxt_s.idx = s_ff.idx + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_ff <= '{st: SXT_SCAN_IDLE, idx: 8'h00, req: 1'b0, busy: 1'b0, done: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign req = s_ff.req;
   assign idx = s_ff.idx;
   assign busy = s_ff.busy;
   assign pass_done = s_ff.done;

endmodule

// ### dv/sxt_far.sv
// Far-side model: acknowledges entry requests and reports sequence passes
`timescale 1ns/100ps
module sxt_far (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic slow,
   input wire logic [7:0] xfer_req,
   input wire logic [1:0] seq_req,
   output logic [7:0] xfer_ack = 8'h00,
   output logic [1:0] seq_done = 2'h0
);
   logic [7:0][1:0] wait_ff;
   logic [1:0][1:0] cnt_ff;
   // Slow answers hold a request three extra cycles, so req and index must stand
   always @(posedge clk_sys) begin
      for (int c = 0; c < 8; c++) begin
         if (reset || !xfer_req[c] || xfer_ack[c]) begin
            xfer_ack[c] <= 1'b0;
            wait_ff[c] <= slow ? 2'h3 : 2'h0;
         end else if (wait_ff[c] != 2'h0) begin
            wait_ff[c] <= wait_ff[c] - 2'h1;
         end else begin
            xfer_ack[c] <= 1'b1;
         end
      end
      // One pass every four cycles leaves no stray pulse before the request falls
      for (int p = 0; p < 2; p++) begin
         cnt_ff[p] <= reset ? 2'h0 : cnt_ff[p] + 2'h1;
         seq_done[p] <= !reset && seq_req[p] && cnt_ff[p] == 2'h3;
      end
   end
endmodule

// ### dv/sxt_regs_chk.sv
// Port assertions for the exchange trigger bank
`timescale 1ns/100ps
module sxt_regs_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [7:0] xfer_req,
   input wire logic [63:0] xfer_idx,
   input wire logic [7:0] xfer_ack,
   input wire logic [7:0] xfer_busy,
   input wire logic [7:0] xfer_pass_done,
   input wire logic [1:0] grp_start,
   input wire logic [31:0] grp_num,
   input wire logic [1:0] seq_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   AST_ACK: assert property (1'b1 |=> reg_ack == $past(reg_wr || reg_rd))
      else $error("ack does not follow access");
   AST_REQ_HOLD: assert property (xfer_req[0] && !xfer_ack[0] && !$past(reg_wr) |=>
      xfer_req[0] && $stable(xfer_idx[7:0])) else $error("request not held");
   AST_REQ_DROP: assert property (xfer_req[0] && xfer_ack[0] && !reg_wr |=>
      !xfer_req[0]) else $error("request not dropped after ack");
   AST_REQ_BUSY: assert property ((xfer_req & ~xfer_busy) == 8'h00)
      else $error("request while idle");
   AST_STOP: assert property ((reg_wr && reg_addr == 16'h0007 && reg_wdata == 16'h0000)
      ##1 !reg_wr |=> xfer_busy[1:0] == 2'b00 && xfer_req[1:0] == 2'b00)
      else $error("read channels not stopped");
   AST_START: assert property ((reg_wr && reg_addr == 16'h0008 && reg_wdata[15:8] == 8'h01)
      ##1 !reg_wr |=> xfer_busy[2]) else $error("bit write channel not started");
   AST_GRP: assert property ((reg_wr && reg_addr == 16'h0015 && reg_wdata != 16'h0000)
      ##1 !reg_wr |=> grp_start[0] && grp_num[15:0] == $past(reg_wdata, 2))
      else $error("group launch wrong");
   AST_SEQ_UP: assert property (reg_wr && reg_addr == 16'h001c && reg_wdata[7:0] != 8'h00
      |-> ##2 seq_req[1]) else $error("sequence request missing");
   AST_SEQ_ZERO: assert property ((reg_wr && reg_addr == 16'h001c && reg_wdata[15:8] == 8'h00)
      ##1 !reg_wr |=> !seq_req[0]) else $error("sequence runs on zero count");
   AST_RST: assert property (disable iff (1'b0) reset |=> !reg_ack && xfer_req == 8'h00
      && grp_start == 2'h0 && seq_req == 2'h0) else $error("outputs active after reset");
   cover property (xfer_pass_done[0]);
   cover property (grp_start[1]);
   cover property (seq_req[0] ##1 !seq_req[0]);
endmodule
bind sxt_regs sxt_regs_chk i_chk (.*);

// ### dv/test_serial_exchange_trigger_regs.sv
// Self-checking bench for the exchange trigger register bank
`timescale 1ns/100ps
module test_serial_exchange_trigger_regs;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic reg_ack;
   logic [7:0] xfer_req, xfer_ack, xfer_busy, xfer_pass_done;
   logic [63:0] xfer_idx;
   logic [1:0] grp_start, seq_req, seq_done;
   logic [31:0] grp_num, send_index, recv_index;
   logic [31:0] map_offset = 32'h0;
   logic slow = 1'b0;
   logic [31:0] seed = 32'h99b64d48;
   logic [7:0][255:0] emap;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int acks [8];
   int dones [2];
   always #5 clk_sys = ~clk_sys;
   sxt_regs i_dut (.*);
   sxt_far i_far (.*);
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [15:0] trig_addr(int c);
      return 16'((c / 4) * 10 + 7 + (c % 4) / 2);
   endfunction
   task automatic check(logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(logic [15:0] a, logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(logic [15:0] a, logic [15:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
      @(posedge clk_sys);
   endtask
   task stop_test();
      $display("Errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      dones[0] += seq_done[0];
      dones[1] += seq_done[1];
      for (int c = 0; c < 8; c++) begin
         if (xfer_req[c] && xfer_ack[c]) begin
            acks[c]++;
            check(emap[c][xfer_idx[8*c +: 8]], 1);
         end
      end
   end
   always @(posedge clk_sys) begin
      if (cyc == 40000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      logic [15:0] w;
      int n;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rd(16'h0015, 16'h0000);
      rd(16'h1003, 16'h0000);
      wr(16'h0100, 16'h5a5a);
      rd(16'h0100, 16'h0000);
      map_offset <= xs();
      for (int i = 0; i < 4; i++) begin
         w = 16'(xs());
         wr(16'h0016 + 16'(i / 2 * 4 + i % 2), w);
         rd(16'h0016 + 16'(i / 2 * 4 + i % 2), w);
         check(i % 2 ? recv_index[16*(i/2) +: 16] : send_index[16*(i/2) +: 16],
            16'(w + map_offset[16*(i/2) +: 16]));
      end
      for (int c = 0; c < 8; c++) begin
         for (int k = 0; k < 16; k++) begin
            w = c < 5 ? 16'(xs()) : 16'hffff;
            w[15] = (k == 15) ? 1'b1 : w[15];
            emap[c][16*k +: 16] = w;
            if (c < 5) wr(16'h1003 + 16'(c * 4096 + k), w);
         end
         if (c < 5) rd(16'h1003 + 16'(c * 4096 + 15), w);
         acks[c] = 0;
         slow <= c[0];
         wr(trig_addr(c), c % 2 ? 16'h0001 : 16'h0100);
         for (int i = 0; i < 3000 && !xfer_pass_done[c]; i++) @(posedge clk_sys);
         check(acks[c], $countones(emap[c]));
         repeat (5) @(posedge clk_sys);
         check(xfer_busy[c], 0);
      end
      slow <= 1'b0;
      for (int v = 0; v < 2; v++) begin
         wr(16'h0007, 16'h0200);
         n = 0;
         for (int i = 0; i < 3000 && n < 2; i++) begin
            @(posedge clk_sys);
            n += xfer_pass_done[0];
         end
         check(n + xfer_busy[0], 3);
         wr(16'h0007, v ? 16'h0300 : 16'h0000);
         @(posedge clk_sys);
         check(xfer_busy[0] | xfer_req[0], 0);
      end
      for (int p = 0; p < 2; p++) begin
         w = 16'(xs() % 255 + 1);
         wr(16'h0015 + 16'(p * 4), w);
         for (int i = 0; i < 8 && !grp_start[p]; i++) @(posedge clk_sys);
         check(grp_num[16*p +: 16], w);
         rd(16'h0015 + 16'(p * 4), 16'h0000);
      end
      n = int'(xs() % 253) + 1;
      dones[0] = 0;
      dones[1] = 0;
      wr(16'h001c, {8'hfe, 8'(n)});
      rd(16'h001c, {8'hfe, 8'(n)});
      for (int i = 0; i < 3000 && seq_req !== 2'b00; i++) @(posedge clk_sys);
      check(dones[0], 254);
      check(dones[1], n);
      wr(16'h001c, 16'hff00);
      repeat (1200) @(posedge clk_sys);
      check(seq_req, 2'b01);
      wr(16'h001c, 16'h0000);
      check(seq_req, 2'b00);
      stop_test();
   end
endmodule
